// ---- verilog/iads_pkg.sv ----
// Package for the in-out alarm gate, delay counter and step counter.
// Assumes a single 20 MHz clock; the 1 MHz count pulses are derived inside.
package iads_pkg;
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1000;
  // 1 MHz count pulse period in clock cycles
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int DELAY_W = 14;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [DELAY_W-1:0] DELAY_ALL_ONES = 14'h3fff;
  localparam logic [1:0] STEP_PRESET = 2'h3;
  localparam logic [1:0] STEP_ZERO = 2'h0;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam int SHIFTS_PER_CYCLE = 4;
  localparam logic [2:0] SHIFT_COUNT = 3'(SHIFTS_PER_CYCLE);

  typedef struct packed {
    logic io_alarm;
    logic sync_initiation;
    logic scope_sync3;
    logic delay_end_carry;
    logic cycle_pulse;
    logic completion;
    logic shift;
    logic clock_restart;
  } iads_pulse_type;

  typedef struct packed {
    logic alarm_arm;
    logic interlock;
    logic clock_stopped;
    logic run;
    logic osync;
    logic end_pend;
    logic tick;
    logic [DIV_W-1:0] div;
    logic [DELAY_W-1:0] count;
    logic [1:0] step;
    logic [2:0] shift_left;
    iads_pulse_type pulse;
  } iads_state_type;
endpackage

// ---- verilog/iads_top.sv ----
// In-out alarm gate, 14-bit delay counter and 2-bit step counter.
// Assumes reset control and the synchronizer run on clk and send
// one-cycle pulses; the synchronizer output is already clk-aligned.
// What this block does
// R1: Armed flag turns unit pulse into alarm
// R2: Interlock setting clears alarm arm flag
// R3: Completion pulse sets alarm arm flag
// R4: External units send initiation when ready
// R5: Delay starts on order or unalarmed pulse
// R6: All ones start gives short delay
// R7: 14-bit counter advances on 1 MHz ticks
// R8: Carry stops run, sets output sync
// R9: Clock pulse reloads ones, emits sync, end-carry
// R10: Counter rests at ones; loadable by pulses
// R11: Counter supports all required delay kinds
// R12: End-carries become cycles, then completion
// R13: Completion clears interlock, restarts clock, exported
// R14: Two-bit counter; carry at three completes
// R15: Counts 0-2 give cycle, four shifts
// R16: Other units preset to three
// R17: Zero load gives three cycles, completion
// R18: Two load gives two delays
// R19: Re-record select sets no interlock
// R20: Preset to three on select, completion
// R21: Three load inputs: three, zero, two
// R22: Orders set interlock; completion clears it
// R23: Reset: ones, idle, step three, disarmed
`timescale 1ns/100ps
`default_nettype none

module iads_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic computer_clock_pulse,
  input wire logic sync_external_unit_pulse,
  input wire logic order_delay_start,
  input wire logic delay_load,
  input wire logic [iads_pkg::DELAY_W-1:0] delay_value,
  input wire logic step_preset,
  input wire logic step_load_zero,
  input wire logic step_load_two,
  input wire logic interlock_set,
  input wire logic select_rerecord,
  input wire logic stop_clock,
  output var iads_pkg::iads_pulse_type pulses,
  output logic interlock,
  output logic alarm_arm,
  output logic delay_running,
  output logic [iads_pkg::DELAY_W-1:0] delay_count,
  output logic [1:0] step_count
);

  iads_pkg::iads_state_type st;
  iads_pkg::iads_state_type next_st;
  logic set_lock;
  logic start_ext;
  logic carry14;

  function automatic logic step_full(input logic [1:0] s);
    // Both bits one: the next add pulse is the completion carry
    return s == iads_pkg::STEP_PRESET;
  endfunction

  always_comb begin
    next_st = st;
    next_st.pulse = '0;
    // Re-record selection completes at once, so no interlock
    set_lock = interlock_set && !select_rerecord; // R19
    start_ext = sync_external_unit_pulse && !st.alarm_arm;
    carry14 = st.run && st.tick && (st.count == iads_pkg::DELAY_ALL_ONES);

    // Free-running 1 MHz count pulse from the 20 MHz clock
    if (st.div == iads_pkg::DIV_LAST) begin
      next_st.div = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 1'b1;
      next_st.tick = 1'b0;
    end

    // Alarm gate
    if (sync_external_unit_pulse) begin
      if (st.alarm_arm) begin
        next_st.pulse.io_alarm = 1'b1; // R1
      end else begin
        next_st.pulse.sync_initiation = 1'b1; // R1
      end
    end
    // Completion arming wins over an order clearing in the same cycle
    if (st.pulse.completion) begin
      next_st.alarm_arm = 1'b1; // R3
    end else if (set_lock) begin
      next_st.alarm_arm = 1'b0; // R2
    end

    // Interlock: a new order wins over a completion in the same cycle
    if (set_lock) begin
      next_st.interlock = 1'b1; // R22
    end else if (st.pulse.completion) begin
      next_st.interlock = 1'b0; // R13 R22
    end
    if (stop_clock) begin
      next_st.clock_stopped = 1'b1;
    end else if (st.pulse.completion && st.clock_stopped) begin
      next_st.clock_stopped = 1'b0;
      next_st.pulse.clock_restart = 1'b1; // R13
    end

    // Delay counter: counts only while running, on tick only
    if (carry14) begin
      next_st.count = '0;
      next_st.run = 1'b0; // R8
      next_st.osync = 1'b1; // R8
    end else if (st.run && st.tick) begin
      next_st.count = st.count + 1'b1; // R7
    end
    // Output sync waits for the computer clock pulse to align end-carry
    if (st.osync && computer_clock_pulse) begin
      // A carry in the same cycle keeps the flag set
      next_st.osync = carry14; // R9
      next_st.count = iads_pkg::DELAY_ALL_ONES; // R9 R10
      next_st.pulse.scope_sync3 = 1'b1; // R9
      next_st.end_pend = 1'b1;
    end else begin
      next_st.end_pend = 1'b0;
    end
    if (st.end_pend) begin
      next_st.pulse.delay_end_carry = 1'b1; // R9
    end
    // Any delay kind is a loaded value; load overrides the reload
    if (delay_load) begin
      next_st.count = delay_value; // R10 R11
    end
    if (order_delay_start || start_ext) begin
      next_st.run = 1'b1; // R5 R6
    end

    // Step counter fed by the delay end-carry
    if (st.pulse.delay_end_carry) begin
      if (step_full(st.step)) begin
        next_st.pulse.completion = 1'b1; // R14 R12
        next_st.step = iads_pkg::STEP_PRESET; // R20 R16
      end else begin
        next_st.pulse.cycle_pulse = 1'b1; // R15 R12
        next_st.step = st.step + 1'b1; // R17 R18
        next_st.shift_left = iads_pkg::SHIFT_COUNT; // R15
      end
    end
    if (step_preset) begin
      next_st.step = iads_pkg::STEP_PRESET; // R21 R20 R16
    end else if (step_load_zero) begin
      next_st.step = iads_pkg::STEP_ZERO; // R21 R17
    end else if (step_load_two) begin
      next_st.step = iads_pkg::STEP_TWO; // R21 R18
    end

    // Four back-to-back shift pulses per cycle pulse
    if (st.shift_left != 3'h0) begin
      next_st.pulse.shift = 1'b1; // R15
      if (!next_st.pulse.cycle_pulse) begin
        next_st.shift_left = st.shift_left - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.count <= iads_pkg::DELAY_ALL_ONES; // R23
      st.step <= iads_pkg::STEP_PRESET; // R23
    end else begin
      st <= next_st;
    end
  end

  assign pulses = st.pulse; // R13
  assign interlock = st.interlock;
  assign alarm_arm = st.alarm_arm;
  assign delay_running = st.run;
  assign delay_count = st.count;
  assign step_count = st.step;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_alarm_when_armed: assert property ( // R1
    sync_external_unit_pulse && st.alarm_arm |=> st.pulse.io_alarm && !st.pulse.sync_initiation)
    else $error("armed unit pulse gave no alarm");
  a_init_when_clear: assert property ( // R1
    sync_external_unit_pulse && !st.alarm_arm |=> st.pulse.sync_initiation && !st.pulse.io_alarm)
    else $error("disarmed unit pulse gave no initiation");
  a_arm_cleared: assert property ( // R2
    interlock_set && !select_rerecord && !st.pulse.completion |=> !st.alarm_arm)
    else $error("interlock order left alarm armed");
  a_arm_on_done: assert property ( // R3
    st.pulse.completion |=> st.alarm_arm && st.interlock == $past(set_lock))
    else $error("completion did not arm alarm");
  a_start_runs: assert property ( // R5
    sync_external_unit_pulse && !st.alarm_arm |=> st.run || st.osync)
    else $error("unalarmed unit pulse did not start delay");
  a_idle_hold: assert property ( // R7
    !st.run && !st.osync && !delay_load |=> $stable(st.count))
    else $error("idle delay counter moved");
  a_carry_stops: assert property ( // R8
    carry14 && !order_delay_start && !start_ext |=> !st.run && st.osync)
    else $error("carry did not stop run");
  a_reload_ones: assert property ( // R9
    st.osync && computer_clock_pulse && !delay_load
    |=> st.pulse.scope_sync3 && st.count == iads_pkg::DELAY_ALL_ONES
    ##1 st.pulse.delay_end_carry)
    else $error("sync pulse did not reload and carry");
  a_done_at_three: assert property ( // R14
    st.pulse.delay_end_carry && st.step == 2'h3 |=> st.pulse.completion && !st.pulse.cycle_pulse)
    else $error("step three gave no completion");
  a_four_shifts: assert property ( // R15
    st.pulse.cycle_pulse |=> st.pulse.shift [*4] ##1 !st.pulse.shift)
    else $error("cycle pulse did not give four shifts");
  a_short_delay: assert property ( // R6
    order_delay_start && !st.run && !st.osync && st.count == iads_pkg::DELAY_ALL_ONES
    && !delay_load |-> ##[1:60] st.osync)
    else $error("all ones start was not short");

  a_run_needs_start: assert property ( // R5
    !st.run && !order_delay_start && !start_ext |=> !st.run)
    else $error("delay ran without a start");

  a_count_hold: assert property ( // R7
    st.run && !st.tick && !delay_load && !st.osync |=> $stable(st.count))
    else $error("delay counter moved between ticks");

  a_count_step: assert property ( // R7
    st.run && st.tick && st.count != iads_pkg::DELAY_ALL_ONES && !delay_load && !st.osync
    |=> st.count == $past(st.count) + 14'h1)
    else $error("tick did not advance delay counter");

  a_osync_waits: assert property ( // R8
    st.osync && !computer_clock_pulse |=> st.osync)
    else $error("output sync left without clock pulse");

  a_osync_clears: assert property ( // R9
    st.osync && computer_clock_pulse && !carry14 |=> !st.osync && st.pulse.scope_sync3)
    else $error("clock pulse did not clear output sync");

  a_end_follows_sync: assert property ( // R9
    st.pulse.scope_sync3 |=> st.pulse.delay_end_carry)
    else $error("scope sync gave no end-carry");

  a_end_needs_sync: assert property ( // R9
    st.pulse.delay_end_carry |-> $past(st.pulse.scope_sync3))
    else $error("end-carry without scope sync");

  a_cycle_below_full: assert property ( // R15
    st.pulse.delay_end_carry && !step_full(st.step)
    |=> st.pulse.cycle_pulse && !st.pulse.completion)
    else $error("step below three gave no cycle pulse");

  a_step_advance: assert property ( // R12
    st.pulse.delay_end_carry && !step_full(st.step)
    && !step_preset && !step_load_zero && !step_load_two
    |=> st.step == $past(st.step) + 2'h1)
    else $error("end-carry below three did not advance step");

  a_full_presets: assert property ( // R20
    st.pulse.delay_end_carry && step_full(st.step) && !step_load_zero && !step_load_two
    |=> step_full(st.step))
    else $error("completion did not preset step counter");

  a_preset_wins: assert property ( // R21
    step_preset |=> st.step == iads_pkg::STEP_PRESET)
    else $error("preset line did not set three");

  a_zero_load: assert property ( // R21
    step_load_zero && !step_preset |=> st.step == iads_pkg::STEP_ZERO)
    else $error("zero line did not set zero");

  a_two_load: assert property ( // R21
    step_load_two && !step_preset && !step_load_zero |=> st.step == iads_pkg::STEP_TWO)
    else $error("two line did not set two");

  a_step_holds: assert property ( // R12
    !st.pulse.delay_end_carry && !step_preset && !step_load_zero && !step_load_two
    |=> $stable(st.step))
    else $error("step counter moved without a pulse");

  a_rerecord_free: assert property ( // R19
    interlock_set && select_rerecord && !st.interlock |=> !st.interlock)
    else $error("re-record select set the interlock");

  a_order_locks: assert property ( // R22
    interlock_set && !select_rerecord |=> st.interlock)
    else $error("order did not set interlock");

  a_lock_holds: assert property ( // R22
    !st.pulse.completion && !set_lock |=> $stable(st.interlock))
    else $error("interlock moved without cause");

  a_arm_holds: assert property ( // R3
    !st.pulse.completion && !set_lock |=> $stable(st.alarm_arm))
    else $error("alarm arm flag moved without cause");

  a_restart_done: assert property ( // R13
    st.pulse.completion && st.clock_stopped && !stop_clock |=> st.pulse.clock_restart)
    else $error("completion did not restart stopped clock");

  a_restart_cause: assert property ( // R13
    st.pulse.clock_restart |-> $past(st.pulse.completion))
    else $error("clock restart without completion");

  a_load_value: assert property ( // R10
    delay_load |=> st.count == $past(delay_value))
    else $error("delay load did not take the value");

endmodule

`default_nettype wire

// ---- tb/iads_eu_model.sv ----
// External tape unit model: sends a synchronized ready pulse on request.
// Assumes the synchronizer is already clk-aligned, as the design expects.
`timescale 1ns/100ps
`default_nettype none
module iads_tape_unit_model (
  input wire logic clk,
  input wire logic fire,
  output logic sync_external_unit_pulse = 1'b0
);
  // One pulse per request; the tape never waits for the program
  always @(posedge clk) begin
    sync_external_unit_pulse <= #1 fire;
  end
endmodule
`default_nettype wire

// ---- tb/iads_top_tb.sv ----
// Bench for the alarm gate, delay counter and step counter.
// Assumes one 20 MHz clock and single-cycle pulses from reset control.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end
module iads_top_tb;
  logic clk = 0, arst_n = 0, ccp = 0, fire = 0, ods = 0, dload = 0;
  logic spre = 0, sz = 0, s2 = 0, ilset = 0, rer = 0, stopc = 0;
  logic [13:0] dval = 14'h3fff;
  logic unit_pulse, interlock, alarm_arm, running;
  logic [13:0] dcount;
  logic [1:0] step;
  iads_pkg::iads_pulse_type pulses;
  int n_fail = 0, comparisons = 0, cycles = 0;
  int n_restart = 0;
  logic [31:0] seed = 32'h00009a06;
  iads_tape_unit_model i_unit (.clk(clk), .fire(fire), .sync_external_unit_pulse(unit_pulse));
  iads_top i_dut (.clk(clk), .arst_n(arst_n), .computer_clock_pulse(ccp),
    .sync_external_unit_pulse(unit_pulse), .order_delay_start(ods), .delay_load(dload),
    .delay_value(dval), .step_preset(spre), .step_load_zero(sz), .step_load_two(s2),
    .interlock_set(ilset), .select_rerecord(rer), .stop_clock(stopc), .pulses(pulses),
    .interlock(interlock), .alarm_arm(alarm_arm), .delay_running(running),
    .delay_count(dcount), .step_count(step));
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Random clock pulses keep the output-sync wait varied
  always begin
    @(posedge clk);
    #1 seed = xs(seed);
    ccp = seed[1:0] == 2'h0;
    cycles++;
    if (cycles > 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic nxt;
    @(posedge clk);
    #1;
  endtask
  task automatic run_delay(input logic start, input logic exp_cyc);
    int n;
    int sh;
    int sc;
    ods = start;
    nxt();
    ods = 0;
    n = 0;
    sc = 0;
    while (pulses.delay_end_carry !== 1'b1 && n < 3000) begin
      sc += (pulses.scope_sync3 === 1'b1);
      nxt();
      n++;
    end
    `CHK(sc, 1)
    `CHK(dcount, 14'h3fff)
    `CHK(running, 1'b0)
    nxt();
    `CHK(pulses.cycle_pulse, exp_cyc)
    `CHK(pulses.completion, ~exp_cyc)
    sh = 0;
    n_restart = 0;
    repeat (6) begin
      sh += (pulses.shift === 1'b1);
      n_restart += (pulses.clock_restart === 1'b1);
      nxt();
    end
    `CHK(sh, exp_cyc ? 4 : 0)
  endtask
  // Looked at once the shift window after completion has passed
  task automatic settle_chk(input logic restart);
    `CHK(interlock, 1'b0)
    `CHK(alarm_arm, 1'b1)
    `CHK(n_restart, restart ? 1 : 0)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1;
    `CHK(dcount, 14'h3fff)
    `CHK({step, alarm_arm, running, interlock}, 5'h18)
    sz = 1;
    ilset = 1;
    nxt();
    {sz, ilset} = 2'h0;
    `CHK(interlock, 1'b1)
    `CHK(step, 2'h0)
    for (int i = 0; i < 4; i++) run_delay(1, i < 3);
    settle_chk(0);
    fire = 1;
    nxt();
    fire = 0;
    nxt();
    `CHK(pulses.io_alarm, 1'b1)
    `CHK(running, 1'b0)
    ilset = 1;
    nxt();
    ilset = 0;
    `CHK(alarm_arm, 1'b0)
    fire = 1;
    nxt();
    fire = 0;
    nxt();
    `CHK(pulses.sync_initiation, 1'b1)
    `CHK(running, 1'b1)
    run_delay(0, 0);
    {s2, dload, ilset, stopc} = 4'hf;
    dval = 14'h3fff - 14'(seed[2:0]);
    nxt();
    {s2, dload, ilset, stopc} = 4'h0;
    `CHK(step, 2'h2)
    run_delay(1, 1);
    run_delay(1, 0);
    settle_chk(1);
    {spre, sz} = 2'h3;
    nxt();
    {spre, sz} = 2'h0;
    `CHK(step, 2'h3)
    run_delay(1, 0);
    {rer, ilset} = 2'h3;
    nxt();
    {rer, ilset} = 2'h0;
    `CHK(interlock, 1'b0)
    report_and_stop();
  end
endmodule
`default_nettype wire
